// File: rtl/hpscr_pkg.sv
/*
 hub power and string configuration register bank: offsets, reset values,
 limits and timing constants. assumes a 20 MHz hub clock.
*/
package hpscr_pkg;
  localparam logic [7:0] ADDR_BUS_MAX_POWER = 8'h0d;
  localparam logic [7:0] ADDR_SELF_CTRL_CURRENT = 8'h0e;
  localparam logic [7:0] ADDR_BUS_CTRL_CURRENT = 8'h0f;
  localparam logic [7:0] ADDR_SETTLE_DELAY = 8'h10;
  localparam logic [7:0] ADDR_LANG_UPPER = 8'h11;
  localparam logic [7:0] ADDR_LANG_LOWER = 8'h12;
  localparam logic [7:0] ADDR_MAKER_LEN = 8'h13;
  localparam logic [7:0] ADDR_PRODUCT_LEN = 8'h14;
  localparam logic [7:0] ADDR_SERIAL_LEN = 8'h15;

  localparam logic [7:0] RESET_CTRL_CURRENT = 8'h32;
  localparam logic [7:0] RESET_CLEAR = 8'h00;
  localparam logic [7:0] MAX_TEXT_CHARS = 8'h1f;
  localparam logic [7:0] NO_LIMIT = 8'hff;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned SETTLE_UNIT_MS = 2;
  localparam int unsigned NS_PER_MS = 1000000;
  localparam int unsigned SETTLE_UNIT_CYCLES = SETTLE_UNIT_MS * NS_PER_MS / CLK_PERIOD_NS;

  typedef enum logic {SETTLE_IDLE, SETTLE_COUNT} hpscr_settle_type;
endpackage

// File: rtl/hpscr_cfg_byte.sv
/*
 one eight-bit configuration register at a fixed offset, with reset value
 and an upper limit on written values. assumes synchronous write strobe.
*/
`timescale 1ns/1ps
module hpscr_cfg_byte #(
  parameter logic [7:0] ADDR = 8'h00,
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] LIMIT = 8'hff
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  output logic [7:0] value_out
);
  wire logic hit = wr_in && (addr_in == ADDR);
  // saturate writes above the limit
  wire logic [7:0] limited = (wdata_in > LIMIT) ? LIMIT : wdata_in;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      value_out <= RESET_VAL;
    end else if (hit) begin
      value_out <= limited;
    end
  end
endmodule

// File: rtl/hpscr_top.sv
/*
 hub power budget, port settle delay, language code and string length
 registers, with a port power settle timer and per-mode current report.
 assumes a byte-wide synchronous configuration port and a 20 MHz clock.
*/
// Summary of operation
// - the bus-powered max power register counts upstream current in 2 mA steps.
// - the self-powered controller current register counts 2 mA steps, board and hub only.
// - the self-powered controller current register resets to 50, meaning 100 mA.
// - the bus-powered controller current register counts 2 mA steps and resets to 50.
// - the settle delay register gives port power settle time in 2 ms steps.
// - the language code is upper register on the high byte, lower register on the low byte.
// - each string length register holds a character count of at most 31.
// - string characters are two bytes each, low byte first at the lower address.
`timescale 1ns/1ps
module hpscr_top #(
  parameter int unsigned SETTLE_CYCLES = hpscr_pkg::SETTLE_UNIT_CYCLES
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [7:0] cfg_addr_in,
  input wire logic [7:0] cfg_wdata_in,
  input wire logic cfg_wr_in,
  input wire logic cfg_rd_in,
  output logic [7:0] cfg_rdata_out,
  input wire logic self_powered_in,
  input wire logic settle_start_in,
  output logic settle_good_out,
  output logic [15:0] lang_id_out,
  output logic [8:0] max_power_ma_out,
  output logic [8:0] controller_current_ma_out,
  output logic [5:0] maker_text_bytes_out,
  output logic [5:0] product_text_bytes_out,
  output logic [5:0] serial_text_bytes_out
);
  logic [7:0] bus_powered_max_power;
  logic [7:0] self_powered_controller_current;
  logic [7:0] bus_powered_controller_current;
  logic [7:0] port_power_settle_delay;
  logic [7:0] language_code_upper;
  logic [7:0] language_code_lower;
  logic [7:0] maker_text_length;
  logic [7:0] product_text_length;
  logic [7:0] serial_text_length;

  hpscr_cfg_byte #(.ADDR(hpscr_pkg::ADDR_BUS_MAX_POWER), .RESET_VAL(hpscr_pkg::RESET_CLEAR),
    .LIMIT(hpscr_pkg::NO_LIMIT)) u_bus_max (.clk_in(clk_in), .resetn_in(resetn_in),
    .addr_in(cfg_addr_in), .wdata_in(cfg_wdata_in), .wr_in(cfg_wr_in),
    .value_out(bus_powered_max_power));
  // defaults to 50 counts
  hpscr_cfg_byte #(.ADDR(hpscr_pkg::ADDR_SELF_CTRL_CURRENT),
    .RESET_VAL(hpscr_pkg::RESET_CTRL_CURRENT),
    .LIMIT(hpscr_pkg::NO_LIMIT)) u_self_cur (.clk_in(clk_in), .resetn_in(resetn_in),
    .addr_in(cfg_addr_in), .wdata_in(cfg_wdata_in), .wr_in(cfg_wr_in),
    .value_out(self_powered_controller_current));
  hpscr_cfg_byte #(.ADDR(hpscr_pkg::ADDR_BUS_CTRL_CURRENT),
    .RESET_VAL(hpscr_pkg::RESET_CTRL_CURRENT),
    .LIMIT(hpscr_pkg::NO_LIMIT)) u_bus_cur (.clk_in(clk_in), .resetn_in(resetn_in),
    .addr_in(cfg_addr_in), .wdata_in(cfg_wdata_in), .wr_in(cfg_wr_in),
    .value_out(bus_powered_controller_current));
  hpscr_cfg_byte #(.ADDR(hpscr_pkg::ADDR_SETTLE_DELAY), .RESET_VAL(hpscr_pkg::RESET_CLEAR),
    .LIMIT(hpscr_pkg::NO_LIMIT)) u_settle (.clk_in(clk_in), .resetn_in(resetn_in),
    .addr_in(cfg_addr_in), .wdata_in(cfg_wdata_in), .wr_in(cfg_wr_in),
    .value_out(port_power_settle_delay));
  hpscr_cfg_byte #(.ADDR(hpscr_pkg::ADDR_LANG_UPPER), .RESET_VAL(hpscr_pkg::RESET_CLEAR),
    .LIMIT(hpscr_pkg::NO_LIMIT)) u_lang_hi (.clk_in(clk_in), .resetn_in(resetn_in),
    .addr_in(cfg_addr_in), .wdata_in(cfg_wdata_in), .wr_in(cfg_wr_in),
    .value_out(language_code_upper));
  hpscr_cfg_byte #(.ADDR(hpscr_pkg::ADDR_LANG_LOWER), .RESET_VAL(hpscr_pkg::RESET_CLEAR),
    .LIMIT(hpscr_pkg::NO_LIMIT)) u_lang_lo (.clk_in(clk_in), .resetn_in(resetn_in),
    .addr_in(cfg_addr_in), .wdata_in(cfg_wdata_in), .wr_in(cfg_wr_in),
    .value_out(language_code_lower));
  // string lengths saturate at 31 characters
  hpscr_cfg_byte #(.ADDR(hpscr_pkg::ADDR_MAKER_LEN), .RESET_VAL(hpscr_pkg::RESET_CLEAR),
    .LIMIT(hpscr_pkg::MAX_TEXT_CHARS)) u_maker (.clk_in(clk_in),
    .resetn_in(resetn_in), .addr_in(cfg_addr_in), .wdata_in(cfg_wdata_in),
    .wr_in(cfg_wr_in), .value_out(maker_text_length));
  hpscr_cfg_byte #(.ADDR(hpscr_pkg::ADDR_PRODUCT_LEN), .RESET_VAL(hpscr_pkg::RESET_CLEAR),
    .LIMIT(hpscr_pkg::MAX_TEXT_CHARS)) u_product (.clk_in(clk_in),
    .resetn_in(resetn_in), .addr_in(cfg_addr_in), .wdata_in(cfg_wdata_in),
    .wr_in(cfg_wr_in), .value_out(product_text_length));
  hpscr_cfg_byte #(.ADDR(hpscr_pkg::ADDR_SERIAL_LEN), .RESET_VAL(hpscr_pkg::RESET_CLEAR),
    .LIMIT(hpscr_pkg::MAX_TEXT_CHARS)) u_serial (.clk_in(clk_in),
    .resetn_in(resetn_in), .addr_in(cfg_addr_in), .wdata_in(cfg_wdata_in),
    .wr_in(cfg_wr_in), .value_out(serial_text_length));

  // read decode
  wire logic [7:0] read_mux =
    (cfg_addr_in == hpscr_pkg::ADDR_BUS_MAX_POWER) ? bus_powered_max_power :
    (cfg_addr_in == hpscr_pkg::ADDR_SELF_CTRL_CURRENT) ? self_powered_controller_current :
    (cfg_addr_in == hpscr_pkg::ADDR_BUS_CTRL_CURRENT) ? bus_powered_controller_current :
    (cfg_addr_in == hpscr_pkg::ADDR_SETTLE_DELAY) ? port_power_settle_delay :
    (cfg_addr_in == hpscr_pkg::ADDR_LANG_UPPER) ? language_code_upper :
    (cfg_addr_in == hpscr_pkg::ADDR_LANG_LOWER) ? language_code_lower :
    (cfg_addr_in == hpscr_pkg::ADDR_MAKER_LEN) ? maker_text_length :
    (cfg_addr_in == hpscr_pkg::ADDR_PRODUCT_LEN) ? product_text_length :
    (cfg_addr_in == hpscr_pkg::ADDR_SERIAL_LEN) ? serial_text_length :
    hpscr_pkg::UNMAPPED_READ;

  // current in mA is twice the 2 mA count
  wire logic [8:0] bus_max_ma = {bus_powered_max_power, 1'b0};
  wire logic [7:0] mode_current = self_powered_in ? self_powered_controller_current :
    bus_powered_controller_current;
  wire logic [8:0] mode_current_ma = {mode_current, 1'b0};
  wire logic [15:0] lang_id = {language_code_upper, language_code_lower};
  // two bytes per character
  wire logic [5:0] maker_bytes = {maker_text_length[4:0], 1'b0};
  wire logic [5:0] product_bytes = {product_text_length[4:0], 1'b0};
  wire logic [5:0] serial_bytes = {serial_text_length[4:0], 1'b0};

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cfg_rdata_out <= hpscr_pkg::UNMAPPED_READ;
      lang_id_out <= 16'h0000;
      max_power_ma_out <= 9'h000;
      controller_current_ma_out <= 9'h000;
      maker_text_bytes_out <= 6'h00;
      product_text_bytes_out <= 6'h00;
      serial_text_bytes_out <= 6'h00;
    end else begin
      if (cfg_rd_in) begin
        cfg_rdata_out <= read_mux;
      end
      lang_id_out <= lang_id;
      max_power_ma_out <= bus_max_ma;
      controller_current_ma_out <= mode_current_ma;
      maker_text_bytes_out <= maker_bytes;
      product_text_bytes_out <= product_bytes;
      serial_text_bytes_out <= serial_bytes;
    end
  end

  // port power settle timer, one step per 2 ms
  hpscr_pkg::hpscr_settle_type state_q;
  logic [31:0] presc_q;
  logic [7:0] steps_q;
  wire logic presc_wrap = (presc_q == 32'(SETTLE_CYCLES - 1));
  wire logic last_step = presc_wrap && (steps_q == 8'h01);
  wire logic load_zero = (port_power_settle_delay == 8'h00);

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q <= hpscr_pkg::SETTLE_IDLE;
      presc_q <= 32'h0000_0000;
      steps_q <= 8'h00;
      settle_good_out <= 1'b0;
    end else if (settle_start_in) begin
      presc_q <= 32'h0000_0000;
      steps_q <= port_power_settle_delay;
      settle_good_out <= load_zero;
      state_q <= load_zero ? hpscr_pkg::SETTLE_IDLE : hpscr_pkg::SETTLE_COUNT;
    end else begin
      unique case (state_q)
        hpscr_pkg::SETTLE_IDLE: begin
        end
        hpscr_pkg::SETTLE_COUNT: begin
          presc_q <= presc_wrap ? 32'h0000_0000 : presc_q + 32'h0000_0001;
          if (presc_wrap) begin
            steps_q <= steps_q - 8'h01;
          end
          if (last_step) begin
            settle_good_out <= 1'b1;
            state_q <= hpscr_pkg::SETTLE_IDLE;
          end
        end
      endcase
    end
  end

  // helper state for the checks below
  logic [31:0] elapsed_q;
  logic [7:0] loaded_q;
  logic self_written_q;
  logic bus_written_q;
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      elapsed_q <= 32'h0000_0000;
      loaded_q <= 8'h00;
      self_written_q <= 1'b0;
      bus_written_q <= 1'b0;
    end else begin
      elapsed_q <= settle_start_in ? 32'h0000_0000 :
        (state_q == hpscr_pkg::SETTLE_COUNT) ? elapsed_q + 32'h0000_0001 : elapsed_q;
      loaded_q <= settle_start_in ? port_power_settle_delay : loaded_q;
      self_written_q <= self_written_q ||
        (cfg_wr_in && cfg_addr_in == hpscr_pkg::ADDR_SELF_CTRL_CURRENT);
      bus_written_q <= bus_written_q ||
        (cfg_wr_in && cfg_addr_in == hpscr_pkg::ADDR_BUS_CTRL_CURRENT);
    end
  end

  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  sequence write_upper_s;
    cfg_wr_in && cfg_addr_in == hpscr_pkg::ADDR_LANG_UPPER;
  endsequence
  sequence write_lower_s;
    cfg_wr_in && cfg_addr_in == hpscr_pkg::ADDR_LANG_LOWER;
  endsequence
  sequence write_then_read_s;
    cfg_wr_in && !cfg_rd_in && cfg_addr_in == hpscr_pkg::ADDR_SETTLE_DELAY
      ##1 cfg_rd_in && !cfg_wr_in && cfg_addr_in == hpscr_pkg::ADDR_SETTLE_DELAY;
  endsequence

  bus_max_scale_a: assert property (1'b1 |=>
    max_power_ma_out == {$past(bus_powered_max_power), 1'b0})
    else $error("bus max power not in 2 mA units");
  self_mode_report_a: assert property (self_powered_in |=>
    controller_current_ma_out == {$past(self_powered_controller_current), 1'b0})
    else $error("self-powered current wrong");
  self_reset_default_a: assert property (!self_written_q |->
    self_powered_controller_current == hpscr_pkg::RESET_CTRL_CURRENT)
    else $error("self-powered default not 50");
  bus_mode_report_a: assert property (!self_powered_in |=>
    controller_current_ma_out == {$past(bus_powered_controller_current), 1'b0})
    else $error("bus-powered current wrong");
  bus_reset_default_a: assert property (!bus_written_q |->
    bus_powered_controller_current == hpscr_pkg::RESET_CTRL_CURRENT)
    else $error("bus-powered default not 50");
  settle_zero_a: assert property (settle_start_in && load_zero |=> settle_good_out)
    else $error("zero settle delay not immediate");
  settle_hold_a: assert property (settle_start_in && !load_zero |=>
    !settle_good_out[*2])
    else $error("settle good too early");
  settle_time_a: assert property ($rose(settle_good_out) &&
    elapsed_q != 32'h0000_0000 |->
    elapsed_q == 32'(loaded_q) * 32'(SETTLE_CYCLES))
    else $error("settle time wrong");
  lang_upper_a: assert property (write_upper_s |=> ##1
    lang_id_out[15:8] == $past(cfg_wdata_in, 2))
    else $error("language upper byte wrong");
  lang_lower_a: assert property (write_lower_s |=> ##1
    lang_id_out[7:0] == $past(cfg_wdata_in, 2))
    else $error("language lower byte wrong");
  text_len_cap_a: assert property (maker_text_length <= hpscr_pkg::MAX_TEXT_CHARS &&
    product_text_length <= hpscr_pkg::MAX_TEXT_CHARS &&
    serial_text_length <= hpscr_pkg::MAX_TEXT_CHARS)
    else $error("string length above 31");
  maker_clamp_a: assert property (cfg_wr_in && cfg_addr_in == hpscr_pkg::ADDR_MAKER_LEN &&
    cfg_wdata_in > hpscr_pkg::MAX_TEXT_CHARS |=>
    maker_text_length == hpscr_pkg::MAX_TEXT_CHARS)
    else $error("string length not held at 31");
  text_bytes_a: assert property (1'b1 |=>
    maker_text_bytes_out == {$past(maker_text_length[4:0]), 1'b0})
    else $error("string byte count wrong");
  product_bytes_a: assert property (1'b1 |=>
    product_text_bytes_out == {$past(product_text_length[4:0]), 1'b0})
    else $error("product byte count wrong");
  serial_bytes_a: assert property (1'b1 |=>
    serial_text_bytes_out == {$past(serial_text_length[4:0]), 1'b0})
    else $error("serial byte count wrong");
  read_back_a: assert property (write_then_read_s |=>
    cfg_rdata_out == $past(cfg_wdata_in, 2))
    else $error("read back mismatch");
endmodule

// File: testbench/hpscr_host_model.sv
/*
 host-side model of the configuration port: byte writes, byte reads, power mode
 and settle start. assumes read data one edge after the strobe; drives on falling edges.
*/
`timescale 1ns/1ps
module hpscr_host_model (
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out,
  output logic wr_out,
  output logic rd_out,
  output logic self_powered_out,
  output logic settle_start_out
);
  initial begin
    addr_out = 8'h00;
    wdata_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
    self_powered_out = 1'b0;
    settle_start_out = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    addr_out = a;
    wdata_out = d;
    wr_out = 1'b1;
    @(negedge clk_in);
    wr_out = 1'b0;
    wdata_out = ~d;
  endtask
  // write then read the same offset on the next edge, data bus changed meanwhile
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(negedge clk_in);
    addr_out = a;
    wdata_out = d;
    wr_out = 1'b1;
    @(negedge clk_in);
    wr_out = 1'b0;
    wdata_out = ~d;
    rd_out = 1'b1;
    @(negedge clk_in);
    rd_out = 1'b0;
    q = rdata_in;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_in);
    addr_out = a;
    rd_out = 1'b1;
    @(negedge clk_in);
    rd_out = 1'b0;
    d = rdata_in;
  endtask
  // self-powered budget never programmed above 50 counts
  task automatic budget(input logic [7:0] d);
    wr(8'h0e, (d > 8'h32) ? 8'h32 : d);
  endtask
  task automatic mode(input logic m);
    @(negedge clk_in);
    self_powered_out = m;
  endtask
  task automatic start();
    @(negedge clk_in);
    settle_start_out = 1'b1;
    @(negedge clk_in);
    settle_start_out = 1'b0;
  endtask
endmodule

// File: testbench/test_hpscr_top.sv
/*
 self-checking bench for the hub power and string register bank.
 assumes the host model drives the port; settle unit shortened to 4 cycles.
*/
`timescale 1ns/1ps
module test_hpscr_top;
  localparam int unsigned SC = 4;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [7:0] addr, wdata, rdata;
  logic wr, rd, selfp, start, good;
  logic [15:0] lang;
  logic [8:0] maxp, ctrl;
  logic [5:0] tbytes [3];
  int n_fail = 0;
  int n_compared = 0;
  int cycles = 0;
  always #25 clk_in = ~clk_in;
  hpscr_host_model host (.clk_in(clk_in), .rdata_in(rdata), .addr_out(addr),
    .wdata_out(wdata), .wr_out(wr), .rd_out(rd), .self_powered_out(selfp),
    .settle_start_out(start));
  hpscr_top #(.SETTLE_CYCLES(SC)) dut (.clk_in(clk_in), .resetn_in(resetn_in),
    .cfg_addr_in(addr), .cfg_wdata_in(wdata), .cfg_wr_in(wr), .cfg_rd_in(rd),
    .cfg_rdata_out(rdata), .self_powered_in(selfp), .settle_start_in(start),
    .settle_good_out(good), .lang_id_out(lang), .max_power_ma_out(maxp),
    .controller_current_ma_out(ctrl), .maker_text_bytes_out(tbytes[0]),
    .product_text_bytes_out(tbytes[1]), .serial_text_bytes_out(tbytes[2]));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic settle_outputs();
    repeat (2) @(negedge clk_in);
  endtask
  task automatic t_reset();
    logic [7:0] v;
    logic [15:0] e;
    host.wr(8'h0c, 8'h77);
    host.wr(8'h16, 8'h55);
    for (int a = 'h0c; a <= 'h16; a++) begin
      host.rd(8'(a), v);
      e = (a == 'h0e || a == 'h0f) ? 16'h0032 : 16'h0000;
      chk("reg after reset", e, {8'h00, v});
    end
    chk("controller ma at reset", 16'h0064, {7'h00, ctrl});
  endtask
  task automatic t_power();
    logic [7:0] v;
    host.wr(8'h0d, 8'hc8);
    host.budget(8'h19);
    host.wr(8'h0f, 8'h40);
    host.mode(1'b1);
    settle_outputs();
    chk("max power ma", 16'd400, {7'h00, maxp});
    chk("self controller ma", 16'd50, {7'h00, ctrl});
    host.rd(8'h0d, v);
    chk("max power readback", 16'h00c8, {8'h00, v});
    host.mode(1'b0);
    settle_outputs();
    chk("bus controller ma", 16'd128, {7'h00, ctrl});
  endtask
  task automatic t_lang();
    logic [7:0] v;
    host.wr(8'h11, 8'h04);
    host.wr(8'h12, 8'h09);
    settle_outputs();
    chk("language id", 16'h0409, lang);
    host.rd(8'h12, v);
    chk("language lower readback", 16'h0009, {8'h00, v});
  endtask
  task automatic t_text();
    logic [7:0] v;
    for (int i = 0; i < 3; i++) begin
      host.wr(8'(8'h13 + i), 8'h20);
      host.rd(8'(8'h13 + i), v);
      chk("text length clamp", 16'h001f, {8'h00, v});
      settle_outputs();
      chk("text bytes at max", 16'd62, {10'h000, tbytes[i]});
      host.wr(8'(8'h13 + i), 8'(5 + i));
      settle_outputs();
      chk("text bytes", 16'(2 * (5 + i)), {10'h000, tbytes[i]});
    end
  endtask
  task automatic t_settle();
    int n;
    logic [7:0] v;
    for (int k = 0; k < 3; k++) begin
      n = (k == 1) ? 0 : 2 - k / 2;
      host.wr_rd(8'h10, 8'(n), v);
      chk("settle delay readback", 16'(n), {8'h00, v});
      host.start();
      // good rises at the edge n * SC after the start edge; zero means at once
      if (n > 0) begin
        chk("settle cleared at start", 16'h0000, {15'h0000, good});
        repeat (n * SC - 1) @(negedge clk_in);
        chk("settle not yet", 16'h0000, {15'h0000, good});
        @(negedge clk_in);
      end
      chk("settle reached", 16'h0001, {15'h0000, good});
    end
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (20) @(negedge clk_in);
    resetn_in = 1'b1;
    t_reset();
    t_power();
    t_lang();
    t_text();
    t_settle();
    tally_and_finish();
  end
endmodule
